// >>> fpa_consts.vh
// Constants for the floating-point ALU conversion and compare slice
// Notes on behaviour
// - Absolute sum negative flag uses pre-abs sign
// - Absolute ops flag overflow, sticky overflow accumulates
// - Absolute sum invalid on NaN or cancelling infinities
// - Truncate option rounds toward zero, else nearest
// - Negate flips sign, NaN gives ones, flags
// - Negate flushes denormal to oppositely signed zero
// - Compare sets zero, negative, invalid flags
// - Compare flushes denormals, clears overflow and carry
// - Less-than conditions false after NaN compare
// - Float to integer adds scale to exponent
// - Float to integer saturates on overflow
// - Float to integer zero, NaN ones, flags
// - Float to integer overflow at exponent 158
// - Float to integer sticky underflow below half
// - Integer to float scales exponent, rounds
// - Integer to float overflow infinity or max
// - Integer to float flag rules, invalid cleared
// - Widen single to extended, flush, NaN ones
// - Narrow extended to single, overflow by option
// - Narrow overflow flag on exponent FE mantissa
// - Clip returns operand or limited signed magnitude
// - No-flag option leaves every flag unchanged
// - Clip NaN gives ones, denormals flush
`ifndef FPA_CONSTS_VH
`define FPA_CONSTS_VH
`define FPA_CMD_OFS 8'h00
`define FPA_BLK_X 3'b001
`define FPA_BLK_Y 3'b010
`define FPA_A_LO 5'h00
`define FPA_A_HI 5'h04
`define FPA_B_LO 5'h08
`define FPA_B_HI 5'h0c
`define FPA_RES_LO 5'h10
`define FPA_RES_HI 5'h14
`define FPA_FLAGS 5'h18
`define FPA_COND 5'h1c
`define FPA_OP_ABS_ADD 4'h0
`define FPA_OP_ABS_SUB 4'h1
`define FPA_OP_ABS 4'h2
`define FPA_OP_NEG 4'h3
`define FPA_OP_CMP 4'h4
`define FPA_OP_FIX 4'h5
`define FPA_OP_FLOAT 4'h6
`define FPA_OP_WIDEN 4'h7
`define FPA_OP_NARROW 4'h8
`define FPA_OP_CLIP 4'h9
`define FPA_CMD_TRN 4
`define FPA_CMD_NF 5
`define FPA_CMD_SCL 6
`define FPA_CMD_EXT 7
`define FPA_CMD_SELX 8
`define FPA_CMD_SELY 9
`define FPA_FLG_RESET 8'h00
`define FPA_EXP_MAX 8'hfe
`define FPA_EXP_TOP 12'd255
`define FPA_FIX_OVF_EXP 12'd158
`define FPA_NARROW_OVF_MAN 31'h7fffff80
`define FPA_INT_POS_SAT 32'h7fffffff
`define FPA_INT_NEG_SAT 32'h80000000
`define FPA_SCL_POS 12'h3ff
`define FPA_SCL_NEG 12'hc01
`define FPA_SCL_LIM 31'd1023
`define FPA_SCL_NEG_LIM 32'hfffffc01
`endif

// >>> fpa_alu.v
// APB-reached floating-point ALU slice with two compute blocks
`timescale 1ns/1ps
`include "fpa_consts.vh"
module fpa_alu (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr
);
    reg [9:0] cmd_r;
    wire wr_done;
    wire [1:0] blk_sel;
    wire go_cmd;
    wire [79:0] opa_bus;
    wire [79:0] opb_bus;
    wire [79:0] res_bus;
    wire [15:0] flg_bus;
    reg [31:0] rd_nxt;
    reg err_nxt;
    reg [1:0] rb;
    reg [7:0] rf;

    function [1:0] blk_of;
        input [7:0] a;
        begin
            blk_of = 2'b00;
            if (a[7:5] == `FPA_BLK_X)
                blk_of = 2'b01;
            if (a[7:5] == `FPA_BLK_Y)
                blk_of = 2'b10;
        end
    endfunction

    function [5:0] lzc40;
        input [39:0] v;
        integer k;
        reg f;
        begin
            lzc40 = 6'd40;
            f = 1'b0;
            for (k = 39; k >= 0; k = k - 1) begin
                if (!f && v[k]) begin
                    lzc40 = 6'd39 - k[5:0];
                    f = 1'b1;
                end
            end
        end
    endfunction

    function [11:0] clamp_scl;
        input [31:0] v;
        begin
            if (!v[31] && v[30:0] > `FPA_SCL_LIM)
                clamp_scl = `FPA_SCL_POS;
            else if (v[31] && v < `FPA_SCL_NEG_LIM)
                clamp_scl = `FPA_SCL_NEG;
            else
                clamp_scl = v[11:0];
        end
    endfunction

    // Returns {overflow, denormal, packed}; single sits in low 32 bits
    function [41:0] rnd_pack;
        input s;
        input [11:0] e;
        input [34:0] m;
        input sgl;
        input trn;
        reg [32:0] kp;
        reg g;
        reg st;
        reg up;
        reg [11:0] ee;
        reg ov;
        reg dn;
        reg [39:0] r;
        begin
            kp = sgl ? {9'h000, m[34:11]} : {1'b0, m[34:3]};
            g = sgl ? m[10] : m[2];
            st = sgl ? |m[9:0] : |m[1:0];
            up = ~trn & g & (st | kp[0]);
            kp = kp + {32'h0, up};
            ee = e;
            if (sgl ? kp[24] : kp[32]) begin
                kp = kp >> 1;
                ee = ee + 12'd1;
            end
            ov = ~ee[11] && ee >= `FPA_EXP_TOP;
            dn = ee[11] || ee == 12'd0;
            if (ov && trn)
                r = sgl ? {8'h00, s, `FPA_EXP_MAX, {23{1'b1}}}
                        : {s, `FPA_EXP_MAX, {31{1'b1}}};
            else if (ov)
                r = sgl ? {8'h00, s, 8'hff, 23'h0} : {s, 8'hff, 31'h0};
            else if (dn)
                r = sgl ? {8'h00, s, 31'h0} : {s, 39'h0};
            else
                r = sgl ? {8'h00, s, ee[7:0], kp[22:0]}
                        : {s, ee[7:0], kp[30:0]};
            rnd_pack = {ov, dn, r};
        end
    endfunction

    assign wr_done = psel & penable & pwrite & pready;
    assign go_cmd = wr_done && paddr == `FPA_CMD_OFS;
    assign blk_sel = {pwdata[`FPA_CMD_SELY], pwdata[`FPA_CMD_SELX]};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : blk
            reg [39:0] opa_r;
            reg [39:0] opb_r;
            reg [39:0] res_r;
            reg [7:0] flg_r;
            reg [39:0] res_nxt;
            reg fz, fn, fv, fi, svs, sus, wres, vld;
            reg [39:0] a40, b40, wa, wb, wbig, wsm, sh, sm, nrm;
            reg az, bz, an_, bn_, ai_, bi_, sa, sb, sbig;
            reg [7:0] d;
            reg [5:0] lz;
            reg [11:0] ex, scl, rr;
            reg [41:0] pk;
            reg [31:0] iv, ip, fr;
            reg [63:0] wide;
            reg eq, lt, up, ext, trn;
            always @* begin
                res_nxt = res_r;
                {fz, fn, fv, fi, svs, sus, wres, vld} = 8'h00;
                ext = pwdata[`FPA_CMD_EXT];
                trn = pwdata[`FPA_CMD_TRN];
                a40 = ext ? opa_r : {opa_r[31:0], 8'h00};
                b40 = ext ? opb_r : {opb_r[31:0], 8'h00};
                az = a40[38:31] == 8'h00;
                bz = b40[38:31] == 8'h00;
                an_ = &a40[38:31] && |a40[30:0];
                bn_ = &b40[38:31] && |b40[30:0];
                ai_ = &a40[38:31] && !an_;
                bi_ = &b40[38:31] && !bn_;
                sa = a40[39];
                sb = b40[39];
                scl = clamp_scl(opb_r[31:0]);
                {wa, wb, wbig, wsm, sh, sm, nrm} = 280'h0;
                {sbig, eq, lt, up} = 4'h0;
                {d, lz, ex, rr, pk, iv, ip, fr, wide} = 240'h0;
                case (pwdata[3:0])
                `FPA_OP_ABS_ADD, `FPA_OP_ABS_SUB, `FPA_OP_ABS: begin
                    vld = 1'b1;
                    wres = 1'b1;
                    if (pwdata[3:0] == `FPA_OP_ABS) begin
                        bz = 1'b1;
                        bn_ = 1'b0;
                        bi_ = 1'b0;
                    end
                    sb = sb ^ (pwdata[3:0] == `FPA_OP_ABS_SUB);
                    fi = an_ | bn_ | (ai_ & bi_ & (sa != sb));
                    if (fi) begin
                        res_nxt = {40{1'b1}};
                    end else if (ai_ | bi_) begin
                        fn = ai_ ? sa : sb;
                        res_nxt = ext ? {9'h0ff, 31'h0} : {9'h000, 8'hff, 23'h0};
                    end else begin
                        wa = az ? 40'h0 : {2'b01, a40[30:0], 7'h00};
                        wb = bz ? 40'h0 : {2'b01, b40[30:0], 7'h00};
                        if ({b40[38:31], wb} > {a40[38:31], wa}) begin
                            wbig = wb;
                            wsm = wa;
                            sbig = sb;
                            d = b40[38:31] - a40[38:31];
                            ex = {4'h0, b40[38:31]};
                        end else begin
                            wbig = wa;
                            wsm = wb;
                            sbig = sa;
                            d = a40[38:31] - b40[38:31];
                            ex = {4'h0, a40[38:31]};
                        end
                        sh = wsm >> d;
                        sh[0] = sh[0] | |(wsm & ~({40{1'b1}} << d));
                        sm = (sa == sb) ? wbig + sh : wbig - sh;
                        lz = lzc40(sm);
                        nrm = sm << lz;
                        ex = ex + 12'd1 - {6'h00, lz};
                        pk = rnd_pack(1'b0, ex, {nrm[39:6], |nrm[5:0]},
                                      ~ext, trn);
                        fn = sbig && sm != 40'h0;
                        fz = pk[40] || sm == 40'h0;
                        sus = pk[40] && sm != 40'h0;
                        fv = pk[41];
                        svs = pk[41];
                        res_nxt = (sm == 40'h0) ? 40'h0 : pk[39:0];
                    end
                end
                `FPA_OP_NEG: begin
                    vld = 1'b1;
                    wres = 1'b1;
                    fi = an_;
                    if (an_)
                        a40 = {40{1'b1}};
                    else if (az)
                        a40 = {~sa, 39'h0};
                    else
                        a40 = {~sa, a40[38:0]};
                    fz = az;
                    fn = a40[39] & ~an_;
                    res_nxt = ext ? a40 : {8'h00, a40[39:8]};
                end
                `FPA_OP_CMP: begin
                    vld = 1'b1;
                    fi = an_ | bn_;
                    wa = az ? 40'h0 : {1'b0, a40[38:0]};
                    wb = bz ? 40'h0 : {1'b0, b40[38:0]};
                    sa = sa & ~az;
                    sb = sb & ~bz;
                    eq = (wa == wb) && (sa == sb);
                    if (sa != sb)
                        lt = sa;
                    else
                        lt = sa ? (wa > wb) : (wa < wb);
                    fz = eq & ~fi;
                    fn = lt & ~fi;
                end
                `FPA_OP_FIX: begin
                    vld = 1'b1;
                    wres = 1'b1;
                    ex = {4'h0, a40[38:31]};
                    if (pwdata[`FPA_CMD_SCL])
                        ex = ex + scl;
                    rr = `FPA_FIX_OVF_EXP - ex;
                    fi = an_;
                    if (an_) begin
                        iv = 32'hffffffff;
                    end else if (az) begin
                        iv = 32'h0;
                    end else if (!ex[11] && ex >= `FPA_FIX_OVF_EXP &&
                                 !(sa && ex == `FPA_FIX_OVF_EXP &&
                                   a40[30:0] == 31'h0)) begin
                        fv = 1'b1;
                        svs = 1'b1;
                        iv = sa ? `FPA_INT_NEG_SAT : `FPA_INT_POS_SAT;
                    end else begin
                        if (!ex[11] && rr < 12'd64)
                            wide = {1'b1, a40[30:0], 32'h0} >> rr[5:0];
                        ip = wide[63:32];
                        fr = wide[31:0];
                        sus = ip == 32'h0 && !fr[31];
                        up = ~trn & fr[31] & (|fr[30:0] | ip[0]);
                        ip = ip + {31'h0, up};
                        if (!sa && ip[31]) begin
                            fv = 1'b1;
                            svs = 1'b1;
                            ip = `FPA_INT_POS_SAT;
                        end
                        iv = sa ? 32'h0 - ip : ip;
                    end
                    fz = iv == 32'h0;
                    fn = iv[31] & ~an_;
                    res_nxt = {8'h00, iv};
                end
                `FPA_OP_FLOAT: begin
                    vld = 1'b1;
                    wres = 1'b1;
                    iv = opa_r[31] ? 32'h0 - opa_r[31:0] : opa_r[31:0];
                    lz = lzc40({iv, 8'h00});
                    nrm = {iv, 8'h00} << lz;
                    ex = 12'd158 - {6'h00, lz};
                    if (pwdata[`FPA_CMD_SCL])
                        ex = ex + scl;
                    pk = rnd_pack(opa_r[31], ex, {nrm[39:6], |nrm[5:0]},
                                  ~ext, trn);
                    res_nxt = (iv == 32'h0) ? 40'h0 : pk[39:0];
                    if (pwdata[`FPA_CMD_SCL]) begin
                        fz = iv == 32'h0 || pk[40];
                        sus = iv != 32'h0 && pk[40];
                        fv = iv != 32'h0 && pk[41];
                        svs = fv;
                    end else begin
                        fz = iv == 32'h0;
                    end
                    fn = opa_r[31] & ~fz;
                end
                `FPA_OP_WIDEN: begin
                    vld = 1'b1;
                    wres = 1'b1;
                    a40 = {opa_r[31:0], 8'h00};
                    az = a40[38:31] == 8'h00;
                    an_ = &a40[38:31] && |a40[30:0];
                    fi = an_;
                    fz = az;
                    fn = a40[39] & ~an_;
                    if (an_)
                        res_nxt = {40{1'b1}};
                    else if (az)
                        res_nxt = {a40[39], 39'h0};
                    else
                        res_nxt = a40;
                end
                `FPA_OP_NARROW: begin
                    vld = 1'b1;
                    wres = 1'b1;
                    a40 = opa_r;
                    az = a40[38:31] == 8'h00;
                    an_ = &a40[38:31] && |a40[30:0];
                    fi = an_;
                    pk = rnd_pack(a40[39], {4'h0, a40[38:31]},
                                  {1'b1, a40[30:0], 3'b000}, 1'b1, trn);
                    if (an_)
                        res_nxt = {8'h00, 32'hffffffff};
                    else if (az)
                        res_nxt = {8'h00, a40[39], 31'h0};
                    else
                        res_nxt = pk[39:0];
                    svs = a40[38:31] == `FPA_EXP_MAX &&
                          a40[30:0] > `FPA_NARROW_OVF_MAN;
                    fv = svs & ~trn;
                    fz = ~an_ && res_nxt[30:0] == 31'h0;
                    fn = ~an_ & res_nxt[31];
                end
                `FPA_OP_CLIP: begin
                    vld = 1'b1;
                    wres = 1'b1;
                    fi = an_ | bn_;
                    wa = az ? 40'h0 : {1'b0, a40[38:0]};
                    wb = bz ? 40'h0 : {1'b0, b40[38:0]};
                    if (fi)
                        a40 = {40{1'b1}};
                    else if (wa < wb)
                        a40 = {sa, wa[38:0]};
                    else
                        a40 = {sa, wb[38:0]};
                    fz = ~fi && a40[38:31] == 8'h00;
                    fn = ~fi & a40[39];
                    res_nxt = ext ? a40 : {8'h00, a40[39:8]};
                end
                default: begin
                    vld = 1'b0;
                end
                endcase
            end

            // Operand writes and execution never collide: one APB write
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    opa_r <= 40'h0;
                    opb_r <= 40'h0;
                    res_r <= 40'h0;
                    flg_r <= `FPA_FLG_RESET;
                end else if (go_cmd && blk_sel[gi] && vld) begin
                    if (wres)
                        res_r <= res_nxt;
                    if (!pwdata[`FPA_CMD_NF])
                        flg_r <= {flg_r[7] | fi, flg_r[6] | sus,
                                  flg_r[5] | svs, 1'b0, fi, fv, fn, fz};
                end else if (wr_done && blk_of(paddr) == (2'b01 << gi)) begin
                    case (paddr[4:0])
                    `FPA_A_LO: opa_r[31:0] <= pwdata;
                    `FPA_A_HI: opa_r[39:32] <= pwdata[7:0];
                    `FPA_B_LO: opb_r[31:0] <= pwdata;
                    `FPA_B_HI: opb_r[39:32] <= pwdata[7:0];
                    `FPA_FLAGS: flg_r <= pwdata[7:0];
                    default: flg_r <= flg_r;
                    endcase
                end
            end
            assign opa_bus[gi*40 +: 40] = opa_r;
            assign opb_bus[gi*40 +: 40] = opb_r;
            assign res_bus[gi*40 +: 40] = res_r;
            assign flg_bus[gi*8 +: 8] = flg_r;
        end
    endgenerate

    // Read data is captured in the setup cycle, so reads take no wait
    always @* begin
        rd_nxt = 32'h0;
        err_nxt = paddr[1:0] != 2'b00;
        rb = blk_of(paddr);
        rf = rb[1] ? flg_bus[15:8] : flg_bus[7:0];
        if (paddr == `FPA_CMD_OFS) begin
            rd_nxt = {22'h0, cmd_r};
        end else if (rb != 2'b00) begin
            case (paddr[4:0])
            `FPA_A_LO: rd_nxt = rb[1] ? opa_bus[71:40] : opa_bus[31:0];
            `FPA_A_HI: rd_nxt = {24'h0, rb[1] ? opa_bus[79:72] : opa_bus[39:32]};
            `FPA_B_LO: rd_nxt = rb[1] ? opb_bus[71:40] : opb_bus[31:0];
            `FPA_B_HI: rd_nxt = {24'h0, rb[1] ? opb_bus[79:72] : opb_bus[39:32]};
            `FPA_RES_LO: rd_nxt = rb[1] ? res_bus[71:40] : res_bus[31:0];
            `FPA_RES_HI: rd_nxt = {24'h0, rb[1] ? res_bus[79:72] : res_bus[39:32]};
            `FPA_FLAGS: rd_nxt = {24'h0, rf};
            `FPA_COND: rd_nxt = {28'h0, ~(rf[1] | rf[0]), ~rf[1],
                                 rf[1] | rf[0], rf[1]};
            default: err_nxt = 1'b1;
            endcase
        end else begin
            err_nxt = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_r <= 10'h000;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable & ~pready;
            if (psel & ~penable) begin
                prdata <= pwrite ? 32'h0 : rd_nxt;
                pslverr <= err_nxt;
            end else if (pready) begin
                pslverr <= 1'b0;
            end
            if (go_cmd)
                cmd_r <= pwdata[9:0];
        end
    end
endmodule // fpa_alu

// >>> fpa_alu_assertions.sv
// Assertion checker watching the APB port of the ALU slice
`timescale 1ns/1ps
module fpa_alu_chk (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB request
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    // APB answer
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    misalign_err_a: assert property (psel && !penable
        && paddr[1:0] != 2'b00 |=> pslverr)
        else $error("misaligned access not refused");
    hole_read_a: assert property (psel && !penable && !pwrite
        && paddr == 8'h04 |=> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    mapped_ok_a: assert property (psel && !penable
        && paddr == 8'h20 |=> !pslverr)
        else $error("mapped access refused");
    cond_inverse_a: assert property (pready && !pwrite && paddr == 8'h3c
        |-> prdata[3:2] == ~prdata[1:0] && (prdata[1] || !prdata[0]))
        else $error("condition bits inconsistent");
    carry_clear_a: assert property (pready && !pwrite && paddr == 8'h38
        |-> prdata[4] == 1'b0 && prdata[31:8] == 24'h0)
        else $error("carry flag or upper flag bits set");
endmodule // fpa_alu_chk

bind fpa_alu fpa_alu_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

// >>> fpa_seq_model.sv
// Sequencer model: APB master issuing operands and commands
`timescale 1ns/1ps
module fpa_seq_model (
    // Clock
    input wire pclk,
    // APB request
    output reg psel = 1'b0,
    output reg penable = 1'b0,
    output reg pwrite = 1'b0,
    output reg [7:0] paddr = 8'h00,
    output reg [31:0] pwdata = 32'h0,
    // APB answer
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    // Request stands until pready is seen high at a rising edge
    task xfer(input w, input [7:0] a, input [31:0] wd,
        output [31:0] rd, output err);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= wd;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
endmodule // fpa_seq_model

// >>> tb_top.sv
// Self-checking bench for the floating-point ALU slice
`timescale 1ns/1ps
`include "fpa_consts.vh"
module tb_top;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    wire psel, penable, pwrite, pready, pslverr;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    integer n_fail = 0;
    integer n_tests = 0;
    reg [31:0] d;
    reg e;
    localparam [9:0] sx = 10'h100, sy = 10'h200, tr = 10'h010;
    localparam [9:0] nf = 10'h020, sc = 10'h040;
    always #12.5 pclk = ~pclk;
    fpa_alu DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    fpa_seq_model sq (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task results;
        begin
            $display("checks %0d mismatches %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task c32(input string nm, input [31:0] ex, input [31:0] got);
        begin
            n_tests = n_tests + 1;
            if (got !== ex) begin
                n_fail = n_fail + 1;
                $display("unexpected %s: expected %h seen %h", nm, ex, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        sq.xfer(1'b1, a, v, d, e);
    endtask
    task rd(input [7:0] a);
        sq.xfer(1'b0, a, 32'h0, d, e);
    endtask
    // Flags are preset so that kept and cleared bits both show
    task op(input [9:0] c, input [39:0] a, input [31:0] b,
        input [7:0] pf, input [31:0] er, input [7:0] ef, input cr);
        reg [7:0] bs;
        begin
            bs = c[9] ? 8'h40 : 8'h20;
            wr(bs + `FPA_A_LO, a[31:0]);
            wr(bs + `FPA_A_HI, {24'h0, a[39:32]});
            wr(bs + `FPA_B_LO, b);
            wr(bs + `FPA_FLAGS, {24'h0, pf});
            wr(`FPA_CMD_OFS, {22'h0, c});
            if (cr) begin
                rd(bs + `FPA_RES_LO);
                c32("result", er, d);
            end
            rd(bs + `FPA_FLAGS);
            c32("flags", {24'h0, ef}, d);
        end
    endtask
    task cnd(input [3:0] ex);
        begin
            rd(8'h3c);
            c32("cond", {28'h0, ex}, d);
        end
    endtask
    initial begin
        #500000;
        n_fail = n_fail + 1;
        results;
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h38);
        c32("reset flags", 32'h0, d);
        rd(8'h00);
        c32("reset cmd", 32'h0, d);
        op(sx, 'h3f800000, 'hc0400000, 0, 'h40000000, 'h02, 1);
        op(sx|2, 'hbf800000, 0, 0, 'h3f800000, 'h02, 1);
        op(sx|1, 'h7f800000, 'h7f800000, 0, 'hffffffff, 'h88, 1);
        op(sx, 'hff800000, 'h7f800000, 0, 'hffffffff, 'h88, 1);
        op(sx, 'h7f7fffff, 'h7f7fffff, 0, 'h7f800000, 'h24, 1);
        op(sx|tr, 'h7f7fffff, 'h7f7fffff, 0, 'h7f7fffff, 'h24, 1);
        op(sx|1, 'h40000000, 'h3f800000, 'h60, 'h3f800000, 'h60, 1);
        op(sx|3, 'h7fc00000, 0, 0, 'hffffffff, 'h88, 1);
        op(sx|3, 'h80000001, 0, 0, 'h00000000, 'h01, 1);
        op(sx|3, 'h3f800000, 0, 'h14, 'hbf800000, 'h02, 1);
        op(sx|10'h080|3, 'h3f80000000, 0, 0, 'h80000000, 'h02, 1);
        op(sx|4, 'h3f800000, 'h40000000, 'h14, 0, 'h02, 0);
        cnd(4'h3);
        op(sx|4, 'h7fc00000, 'h3f800000, 0, 0, 'h88, 0);
        cnd(4'hc);
        op(sx|4, 'h00000001, 'h80000000, 'h14, 0, 'h01, 0);
        cnd(4'h6);
        op(sx|5, 'h3fc00000, 0, 0, 2, 'h00, 1);
        op(sx|tr|5, 'h3fc00000, 0, 0, 1, 'h00, 1);
        op(sx|sc|5, 'h3f800000, 3, 0, 8, 'h00, 1);
        op(sx|5, 'h4f000000, 0, 0, 'h7fffffff, 'h24, 1);
        op(sx|5, 'hcf000000, 0, 0, 'h80000000, 'h02, 1);
        op(sx|sc|5, 'hbf800000, 32, 0, 'h80000000, 'h26, 1);
        op(sx|5, 'h3e800000, 0, 0, 0, 'h41, 1);
        op(sx|5, 'h7fc00000, 0, 0, 'hffffffff, 'h88, 1);
        op(sx|6, 1, 0, 'h0c, 'h3f800000, 'h00, 1);
        op(sx|tr|6, 'hffffffff, 0, 0, 'hbf800000, 'h02, 1);
        op(sx|sc|6, 1, 200, 0, 'h7f800000, 'h24, 1);
        op(sx|sc|tr|6, 1, 200, 0, 'h7f7fffff, 'h24, 1);
        op(sx|7, 'h3f800000, 0, 0, 'h80000000, 'h00, 1);
        op(sx|7, 'h00000001, 0, 0, 0, 'h01, 1);
        op(sx|7, 'h7fc00000, 0, 0, 'hffffffff, 'h88, 1);
        op(sx|8, 'h7f7fffffc0, 0, 0, 'h7f800000, 'h24, 1);
        op(sx|tr|8, 'h7f7fffffc0, 0, 0, 'h7f7fffff, 'h20, 1);
        op(sx|8, 'h3f80000000, 0, 0, 'h3f800000, 'h00, 1);
        op(sx|9, 'hc0400000, 'h40000000, 0, 'hc0000000, 'h02, 1);
        op(sx|9, 'h3f800000, 'h40000000, 0, 'h3f800000, 'h00, 1);
        op(sx|9, 'h7fc00000, 'h40000000, 0, 'hffffffff, 'h88, 1);
        op(sx|nf|5, 'h7fc00000, 0, 'h24, 'hffffffff, 'h24, 1);
        op(sy|3, 'h3f800000, 0, 0, 'hbf800000, 'h02, 1);
        rd(8'h30);
        c32("x result kept", 32'hffffffff, d);
        wr(8'h20, 32'h40400000);
        op(sx|sy|3, 'h40000000, 0, 0, 'hc0000000, 'h02, 1);
        rd(8'h30);
        c32("x result both", 32'hc0400000, d);
        rd(8'h04);
        c32("hole error", 32'h1, {31'h0, e});
        c32("hole data", 32'h0, d);
        wr(8'h21, 32'h1);
        c32("misaligned error", 32'h1, {31'h0, e});
        results;
    end
endmodule // tb_top
